/* File: logic/adc_acquisition_control.sv */
// acquisition controller: two-wire slave, register bank, conversion sequencer
`default_nettype none
module adc_acquisition_control
    import acq_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // two-wire bus, open drain
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // trim and modulator
    input wire logic [2:0] i_addr_trim,
    input wire logic i_mod_bit,
    // status and analog controls
    output logic o_samp_tick,
    output logic o_chop,
    output logic o_ready,
    output logic o_busy,
    output logic o_osc_en,
    output analog_cfg_t o_cfg
);

    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // boot phase: trim load before the bus is served
    logic [7:0] boot_cnt_r;
    logic booting_r;
    logic [6:0] slave_addr_r;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            boot_cnt_r <= 8'h00;
            booting_r <= 1'b1;
            slave_addr_r <= SLAVE_ADDR_BASE;
        end else if (booting_r) begin
            if (boot_cnt_r == BOOT_CYC - 8'h01) begin
                booting_r <= 1'b0;
                slave_addr_r <= SLAVE_ADDR_BASE | {4'h0, i_addr_trim};
            end else begin
                boot_cnt_r <= boot_cnt_r + 8'h01;
            end
        end
    end

    // bus line edges
    logic scl_q_r;
    logic sda_q_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= i_scl;
            sda_q_r <= i_sda;
        end
    end

    assign scl_rise = i_scl & ~scl_q_r;
    assign scl_fall = ~i_scl & scl_q_r;
    assign start_det = i_scl & scl_q_r & sda_q_r & ~i_sda;
    assign stop_det = i_scl & scl_q_r & ~sda_q_r & i_sda;

    // register bank storage
    logic [5:0][7:0] cfg_r;
    logic [15:0] res_r;
    logic busy_r;
    logic [7:0] rd_data;
    logic [7:0] idx_r;

    always_comb begin
        rd_data = 8'h00;
        if (idx_r == IDX_RES_LO) begin
            rd_data = res_r[7:0];
        end else if (idx_r == IDX_RES_HI) begin
            rd_data = res_r[15:8];
        end else if (idx_r >= IDX_CFG0 && idx_r <= IDX_CFG5) begin
            rd_data = cfg_r[3'(idx_r - IDX_CFG0)];
            if (idx_r == IDX_CFG5) begin
                rd_data[BUSY_BIT] = busy_r;
            end
        end
    end

    // slave only, clock held only to stretch
    bus_state_t bus_st_r;
    logic [7:0] shreg_r;
    logic [3:0] bitcnt_r;
    logic rw_r;
    logic idx_phase_r;
    logic nack_r;
    logic [3:0] stretch_r;
    logic sda_oe_r;
    logic scl_oe_r;
    logic wr_en_r;
    logic [7:0] wr_idx_r;
    logic [7:0] wr_data_r;

    sequence addr_end;
        bus_st_r == S_ADDR && scl_fall && bitcnt_r == 4'h8;
    endsequence

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bus_st_r <= S_IDLE;
            shreg_r <= 8'h00;
            bitcnt_r <= 4'h0;
            rw_r <= 1'b0;
            idx_phase_r <= 1'b0;
            idx_r <= 8'h00;
            nack_r <= 1'b0;
            stretch_r <= 4'h0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            wr_en_r <= 1'b0;
            wr_idx_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_en_r <= 1'b0;
            if (stretch_r != 4'h0) begin
                stretch_r <= stretch_r - 4'h1;
                if (stretch_r == 4'h1) begin
                    scl_oe_r <= 1'b0;
                end
            end
            if (booting_r || stop_det) begin
                bus_st_r <= S_IDLE;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
                stretch_r <= 4'h0;
            end else if (start_det) begin
                bus_st_r <= S_ADDR;
                bitcnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
            end else begin
                unique case (bus_st_r)
                    S_IDLE: begin
                    end
                    S_ADDR, S_WR: begin
                        if (scl_rise) begin
                            shreg_r <= {shreg_r[6:0], i_sda};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                        if (scl_fall && bitcnt_r == 4'h8) begin
                            bitcnt_r <= 4'h0;
                            if (bus_st_r == S_WR || shreg_r[7:1] == slave_addr_r) begin
                                bus_st_r <= S_ACK;
                                sda_oe_r <= 1'b1;
                                scl_oe_r <= 1'b1;
                                stretch_r <= STRETCH_CYC;
                            end else begin
                                bus_st_r <= S_IDLE;
                            end
                            if (bus_st_r == S_ADDR) begin
                                rw_r <= shreg_r[0];
                                idx_phase_r <= ~shreg_r[0];
                            end else if (idx_phase_r) begin
                                idx_r <= shreg_r;
                                idx_phase_r <= 1'b0;
                            end else begin
                                wr_en_r <= 1'b1;
                                wr_idx_r <= idx_r;
                                wr_data_r <= shreg_r;
                                idx_r <= idx_r + 8'h01;
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            if (rw_r) begin
                                bus_st_r <= S_RD;
                                sda_oe_r <= ~rd_data[7];
                                shreg_r <= {rd_data[6:0], 1'b0};
                                bitcnt_r <= 4'h1;
                                idx_r <= idx_r + 8'h01;
                            end else begin
                                bus_st_r <= S_WR;
                                sda_oe_r <= 1'b0;
                            end
                        end
                    end
                    S_RD: begin
                        if (scl_fall) begin
                            if (bitcnt_r == 4'h8) begin
                                sda_oe_r <= 1'b0;
                                bus_st_r <= S_RACK;
                                bitcnt_r <= 4'h0;
                            end else begin
                                sda_oe_r <= ~shreg_r[7];
                                shreg_r <= {shreg_r[6:0], 1'b0};
                                bitcnt_r <= bitcnt_r + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            nack_r <= i_sda;
                        end
                        if (scl_fall) begin
                            if (nack_r) begin
                                bus_st_r <= S_IDLE;
                            end else begin
                                bus_st_r <= S_RD;
                                sda_oe_r <= ~rd_data[7];
                                shreg_r <= {rd_data[6:0], 1'b0};
                                bitcnt_r <= 4'h1;
                                idx_r <= idx_r + 8'h01;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // configuration registers
    logic start_pend_r;
    logic restore_r;
    logic launch;
    logic [2:0] wr_off;

    assign wr_off = 3'(wr_idx_r - IDX_CFG0);

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_r <= CFG_RST;
            restore_r <= 1'b0;
        end else begin
            restore_r <= 1'b0;
            if (wr_en_r && wr_idx_r >= IDX_CFG0 && wr_idx_r <= IDX_CFG5) begin
                if (wr_idx_r == IDX_CFG5 && wr_data_r[RESTORE_BIT]) begin
                    cfg_r <= CFG_RST;
                    restore_r <= 1'b1;
                end else begin
                    cfg_r[wr_off] <= wr_data_r & CFG_WMASK[wr_off];
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            start_pend_r <= 1'b0;
        end else if (wr_en_r && wr_idx_r == IDX_CFG0 && wr_data_r[START_BIT]) begin
            start_pend_r <= 1'b1;
        end else if (launch) begin
            start_pend_r <= 1'b0;
        end
    end

    // conversion sequencer
    conv_state_t cst_r;
    logic [8:0] div_r;
    logic [8:0] period_l;
    logic [10:0] samp_cnt_r;
    logic [10:0] ovs_last;
    logic [2:0] elem_cnt_r;
    logic [2:0] ecnt_last;
    logic [1:0] ecnt_l;
    logic [2:0] ovs_l;
    logic chop_r;
    logic signed [14:0] acc_r;
    logic signed [14:0] acc_nxt;
    logic signed [31:0] code_wide;
    logic [15:0] code_sat;
    logic [3:0] shift_amt;
    logic tick;
    logic done_w;
    logic continuous_run;
    logic ready_r;
    logic samp_tick_r;

    assign continuous_run = cfg_r[0][RUN_BIT];
    assign ovs_last = (11'h008 << ovs_l) - 11'h001;
    assign ecnt_last = 3'((4'h1 << ecnt_l) - 4'h1);
    assign tick = cst_r == C_RUN && div_r == period_l - 9'h001;
    assign done_w = tick && samp_cnt_r == ovs_last && elem_cnt_r == ecnt_last;
    assign launch = restore_r || ((cst_r == C_IDLE || done_w) && (start_pend_r || continuous_run));

    assign acc_nxt = acc_r + ((i_mod_bit ^ chop_r) ? 15'sh0001 : -15'sh0001);
    assign shift_amt = SHIFT_TOP - {1'b0, ovs_l} - {2'b00, ecnt_l};
    assign code_wide = 32'(acc_nxt) <<< shift_amt;
    assign code_sat = (code_wide > CODE_MAX) ? CODE_MAX[15:0] : code_wide[15:0];

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cst_r <= C_IDLE;
            busy_r <= 1'b0;
            div_r <= 9'h000;
            period_l <= SAMP_CYC_MAX;
            samp_cnt_r <= 11'h000;
            elem_cnt_r <= 3'h0;
            ecnt_l <= 2'h0;
            ovs_l <= 3'h0;
            chop_r <= 1'b0;
            acc_r <= 15'sh0000;
        end else if (launch) begin
            cst_r <= C_RUN;
            busy_r <= 1'b1;
            div_r <= 9'h000;
            // every rate divided from one clock
            period_l <= SAMP_CYC_MAX << (2'h3 - cfg_r[2][7:6]);
            samp_cnt_r <= 11'h000;
            elem_cnt_r <= 3'h0;
            ecnt_l <= cfg_r[0][ECNT_LSB +: 2];
            ovs_l <= cfg_r[0][OVS_LSB +: 3];
            chop_r <= 1'b0;
            acc_r <= 15'sh0000;
        end else if (done_w) begin
            cst_r <= C_IDLE;
            busy_r <= 1'b0;
        end else if (tick) begin
            div_r <= 9'h000;
            acc_r <= acc_nxt;
            if (samp_cnt_r == ovs_last) begin
                samp_cnt_r <= 11'h000;
                chop_r <= ~chop_r;
                elem_cnt_r <= elem_cnt_r + 3'h1;
            end else begin
                samp_cnt_r <= samp_cnt_r + 11'h001;
            end
        end else if (cst_r == C_RUN) begin
            div_r <= div_r + 9'h001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            res_r <= 16'h0000;
            ready_r <= 1'b0;
            samp_tick_r <= 1'b0;
        end else begin
            ready_r <= done_w;
            samp_tick_r <= tick;
            if (done_w) begin
                res_r <= code_sat;
            end
        end
    end

    logic osc_en_r;
    logic zero_r;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            osc_en_r <= 1'b1;
            zero_r <= 1'b0;
        end else begin
            osc_en_r <= booting_r || bus_st_r != S_IDLE || busy_r || !i_scl || !i_sda;
            zero_r <= 1'b0;
        end
    end

    assign o_scl_o = zero_r;
    assign o_scl_oe = scl_oe_r;
    assign o_sda_o = zero_r;
    assign o_sda_oe = sda_oe_r;
    assign o_samp_tick = samp_tick_r;
    assign o_chop = chop_r;
    assign o_ready = ready_r;
    assign o_busy = busy_r;
    assign o_osc_en = osc_en_r;

    // one assignment for the whole struct keeps a single driver on it
    assign o_cfg = '{
        modulator_bias_sel: cfg_r[1][7:6],
        amplifier_bias_sel: cfg_r[1][5:4],
        enable: cfg_r[1][3:0],
        sample_clock_sel: cfg_r[2][7:6],
        stage1_gain: cfg_r[3][7],
        stage2_gain: cfg_r[2][5:4],
        stage2_offset: cfg_r[2][3:0],
        stage3_gain: cfg_r[3][6:0],
        stage3_offset: cfg_r[4][6:0],
        input_select: cfg_r[5][5:1],
        reference_select: cfg_r[5][0]
    };

    // independent sample count, cross-checks the nested counters
    logic [13:0] samp_seen_r;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            samp_seen_r <= 14'h0000;
        end else if (launch) begin
            samp_seen_r <= 14'h0000;
        end else if (tick) begin
            samp_seen_r <= samp_seen_r + 14'h0001;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rst_n_r);

    result_load_a: assert property (done_w |=> res_r == $past(code_sat))
        else $error("result not loaded at end of conversion");
    twos_sign_a: assert property (done_w && acc_nxt > 15'sh0000 |=> !res_r[15])
        else $error("positive sum gave negative code");
    start_once_a: assert property (cst_r == C_IDLE && start_pend_r |=> busy_r && !start_pend_r)
        else $error("queued start not taken");
    elem_count_a: assert property (done_w |-> samp_seen_r == 14'((14'h0008 << ovs_l << ecnt_l) - 14'h0001))
        else $error("conversion ended at wrong count");
    ovs_bound_a: assert property (busy_r |-> samp_cnt_r <= ovs_last)
        else $error("sample count past ratio");
    continuous_run_relaunch_a: assert property (done_w && continuous_run |=> busy_r && samp_cnt_r == 11'h000)
        else $error("continuous mode did not relaunch");
    busy_state_a: assert property (busy_r == (cst_r == C_RUN))
        else $error("busy disagrees with sequencer");
    restore_start_a: assert property (restore_r |=> busy_r && div_r == 9'h000 && cfg_r == CFG_RST)
        else $error("restore did not restart with defaults");
    stretch_ack_a: assert property ($rose(scl_oe_r) |-> bus_st_r == S_ACK && sda_oe_r)
        else $error("clock stretched outside ack");
    addr_miss_a: assert property (addr_end and (shreg_r[7:1] != slave_addr_r)
        |=> bus_st_r == S_IDLE && !sda_oe_r)
        else $error("foreign address acknowledged");

endmodule
`default_nettype wire

/* File: logic/acq_pkg.sv */
// shared constants and types for the acquisition controller
`default_nettype none
package acq_pkg;
    // clocking
    localparam int SYS_HZ = 25_000_000;
    localparam int SAMP_HZ_MAX = 500_000;
    localparam logic [8:0] SAMP_CYC_MAX = 9'(SYS_HZ / SAMP_HZ_MAX);
    localparam int BOOT_TIME_NS = 10_000;
    localparam logic [7:0] BOOT_CYC = 8'((BOOT_TIME_NS * (SYS_HZ / 1_000_000) + 999) / 1000);
    localparam int STRETCH_NS = 200;
    localparam logic [3:0] STRETCH_CYC = 4'((STRETCH_NS * (SYS_HZ / 1_000_000) + 999) / 1000);
    // slave address
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h48;
    // register indices
    localparam logic [7:0] IDX_RES_LO = 8'h00;
    localparam logic [7:0] IDX_RES_HI = 8'h01;
    localparam logic [7:0] IDX_CFG0 = 8'h02;
    localparam logic [7:0] IDX_CFG5 = 8'h07;
    // field positions
    localparam int START_BIT = 7;
    localparam int ECNT_LSB = 5;
    localparam int OVS_LSB = 2;
    localparam int RUN_BIT = 1;
    localparam int BUSY_BIT = 7;
    localparam int RESTORE_BIT = 6;
    // reset values and writable masks, element 0 is conversion_control
    localparam logic [5:0][7:0] CFG_RST = {8'h00, 8'h00, 8'h0C, 8'hC0, 8'hF0, 8'h28};
    localparam logic [5:0][7:0] CFG_WMASK = {8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h7E};
    // result limits
    localparam logic signed [31:0] CODE_MAX = 32'sh0000_7FFF;
    localparam logic [3:0] SHIFT_TOP = 4'hC;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ADDR = 6'h02,
        S_ACK = 6'h04,
        S_WR = 6'h08,
        S_RD = 6'h10,
        S_RACK = 6'h20
    } bus_state_t;

    typedef enum logic [1:0] {
        C_IDLE = 2'h1,
        C_RUN = 2'h2
    } conv_state_t;

    typedef struct packed {
        logic [1:0] modulator_bias_sel;
        logic [1:0] amplifier_bias_sel;
        logic [3:0] enable;
        logic [1:0] sample_clock_sel;
        logic stage1_gain;
        logic [1:0] stage2_gain;
        logic [3:0] stage2_offset;
        logic [6:0] stage3_gain;
        logic [6:0] stage3_offset;
        logic [4:0] input_select;
        logic reference_select;
    } analog_cfg_t;
endpackage
`default_nettype wire

/* File: bench/host_master.sv */
// two-wire bus master model standing in for the host controller
`default_nettype none
module host_master (
    // clock and wire levels
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    // line pulls and read results
    output logic o_scl_low,
    output logic o_sda_low,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus rate: three phases of 21 cycles keep a bit under 400 kHz
    localparam int HALF = 21;
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_data = 8'h00;
    end
    task automatic phase();
        repeat (HALF) @(posedge i_clk);
    endtask
    // stretch wait: the slave may hold the clock low, bounded here
    task automatic rise();
        int n;
        n = 0;
        o_scl_low <= 1'b0;
        while (!i_scl && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        phase();
    endtask
    task automatic bit_io(input logic b, output logic s);
        phase();
        o_sda_low <= !b;
        phase();
        rise();
        s = i_sda;
        o_scl_low <= 1'b1;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(mack, s);
        ack = !s;
    endtask
    task automatic start();
        phase();
        o_sda_low <= 1'b0;
        phase();
        rise();
        o_sda_low <= 1'b1;
        phase();
        o_scl_low <= 1'b1;
    endtask
    task automatic stop();
        phase();
        o_sda_low <= 1'b1;
        phase();
        rise();
        o_sda_low <= 1'b0;
        phase();
    endtask
    // access order: address, index, then data or a restart and reads
    task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic k0, k1, k2;
        start();
        xfer({a, 1'b0}, 1'b1, rx, k0);
        xfer(idx, 1'b1, rx, k1);
        xfer(d, 1'b1, rx, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, input int n);
        logic [7:0] rx;
        logic k;
        start();
        xfer({a, 1'b0}, 1'b1, rx, k);
        xfer(idx, 1'b1, rx, k);
        start();
        xfer({a, 1'b1}, 1'b1, rx, k);
        // the last byte is refused so the slave lets go of the data line
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, 1'(i == n - 1), rx, k);
            o_rd_data <= rx;
            o_rd_valid <= 1'b1;
            @(posedge i_clk);
            o_rd_valid <= 1'b0;
        end
        stop();
    endtask
endmodule
`default_nettype wire

/* File: bench/adc_acquisition_control_tb_top.sv */
// testbench for the acquisition controller driven by the bus master model
`default_nettype none
module adc_acquisition_control_tb_top import acq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CLK_SEL [3] = '{8'h00, 8'h40, 8'h80};
    localparam logic [7:0] CTRL [3] = '{8'h80, 8'hA0, 8'h84};
    localparam int LEN [3] = '{3200, 3200, 1600};
    localparam int SAMPS [3] = '{8, 16, 16};
    logic i_clk_sys, i_rst_b, i_mod_bit, pol, scl_low, sda_low, rd_valid, scl_w, sda_w;
    logic o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_chop, o_ready, o_busy, o_samp_tick, o_osc_en;
    logic [2:0] i_addr_trim;
    logic [7:0] rd_data;
    analog_cfg_t o_cfg;
    int miscompares = 0, compares = 0, readies = 0, busy_cnt = 0, exp_len = 0, cyc = 0;
    int ticks = 0, exp_samp = 0;
    logic [7:0] exp_q[$];
    string name_q[$];
    // open-drain wires with pull-ups
    assign scl_w = !(scl_low | (o_scl_oe & !o_scl_o));
    assign sda_w = !(sda_low | (o_sda_oe & !o_sda_o));
    initial i_clk_sys = 1'b0;
    always #20 i_clk_sys = !i_clk_sys;
    adc_acquisition_control i_adc_acquisition_control (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl_w), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
        .i_sda(sda_w), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_addr_trim(i_addr_trim),
        .i_mod_bit(i_mod_bit), .o_samp_tick(o_samp_tick), .o_chop(o_chop), .o_ready(o_ready),
        .o_busy(o_busy), .o_osc_en(o_osc_en), .o_cfg(o_cfg)
    );
    host_master i_host_master (
        .i_clk(i_clk_sys), .i_scl(scl_w), .i_sda(sda_w), .o_scl_low(scl_low), .o_sda_low(sda_low),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data)
    );
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic note(input logic [7:0] v, input string what);
        exp_q.push_back(v);
        name_q.push_back(what);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic ok;
        i_host_master.write_reg(SLAVE_ADDR_BASE, idx, d, ok);
        check("write ack", 16'(ok), 16'h0001);
    endtask
    task automatic rd(input logic [7:0] idx, input int n);
        i_host_master.read_reg(SLAVE_ADDR_BASE, idx, n);
    endtask
    task automatic wait_ready(input int n);
        int t;
        t = 0;
        while (readies < n && t < 5000) begin
            @(posedge i_clk_sys);
            t++;
        end
        check("conversion done", 16'(readies >= n), 16'h0001);
    endtask
    // the modulator model makes every sample agree with pol once chopping is undone
    always @(posedge i_clk_sys) begin
        i_mod_bit <= o_chop ^ pol;
        cyc++;
        if (rd_valid)
            check(name_q.pop_front(), 16'(rd_data), 16'(exp_q.pop_front()));
        busy_cnt <= o_ready ? 0 : (o_busy ? busy_cnt + 1 : 0);
        ticks <= o_ready ? 0 : ticks + 32'(o_samp_tick);
        if (o_ready) begin
            readies++;
            check("length", 16'(busy_cnt > exp_len - 3 && busy_cnt < exp_len + 3), 16'h0001);
            check("samples", 16'(ticks + 32'(o_samp_tick)), 16'(exp_samp));
        end
        if (cyc == 90000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        logic [7:0] d;
        logic ok;
        int n;
        i_rst_b = 1'b0;
        i_addr_trim = 3'h0;
        pol = 1'b1;
        void'($urandom(32'h37A2F05D));
        repeat (10) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (300) @(posedge i_clk_sys);
        check("oscillator asleep", 16'(o_osc_en), 16'h0000);
        for (int i = 0; i < 6; i++) note(CFG_RST[i], "default");
        rd(8'h02, 6);
        $display("test defaults done");
        d = 8'($urandom);
        wr(8'h03, d);
        check("enable", 16'(o_cfg.enable), 16'(d[3:0]));
        check("modulator bias", 16'(o_cfg.modulator_bias_sel), 16'(d[7:6]));
        note(d, "bias readback");
        rd(8'h03, 1);
        d = 8'($urandom);
        wr(8'h06, d);
        note(d & 8'h7F, "offset readback");
        rd(8'h06, 1);
        wr(8'h09, d);
        note(8'h00, "unmapped");
        rd(8'h09, 1);
        i_host_master.write_reg(SLAVE_ADDR_BASE | 7'h01, 8'h03, 8'h00, ok);
        check("foreign address", 16'(ok), 16'h0000);
        $display("test registers done");
        for (int k = 0; k < 3; k++) begin
            pol <= (k != 1);
            wr(8'h04, CLK_SEL[k]);
            check("sample clock", 16'(o_cfg.sample_clock_sel), 16'(CLK_SEL[k][7:6]));
            exp_len = LEN[k];
            exp_samp = SAMPS[k];
            n = readies + 1;
            wr(8'h02, CTRL[k]);
            wait_ready(n);
            note(k != 1 ? 8'hFF : 8'h00, "result low");
            note(k != 1 ? 8'h7F : 8'h80, "result high");
            note(CTRL[k] & 8'h7F, "start readback");
            rd(8'h00, 3);
        end
        $display("test conversions done");
        wr(8'h07, 8'h2B);
        check("input select", 16'(o_cfg.input_select), 16'h0015);
        check("reference", 16'(o_cfg.reference_select), 16'h0001);
        wr(8'h03, 8'h0F);
        exp_len = 3200;
        exp_samp = 64;
        n = readies + 1;
        wr(8'h07, 8'h40);
        note(8'h80, "busy flag");
        rd(8'h07, 1);
        for (int i = 0; i < 6; i++) note(CFG_RST[i], "restored");
        rd(8'h02, 6);
        wait_ready(n);
        $display("test restore done");
        n = readies + 3;
        exp_len = 400;
        exp_samp = 8;
        wr(8'h02, 8'h02);
        wait_ready(n);
        check("busy across runs", 16'(o_busy), 16'h0001);
        check("oscillator on", 16'(o_osc_en), 16'h0001);
        wr(8'h02, 8'h00);
        repeat (450) @(posedge i_clk_sys);
        check("busy after stop", 16'(o_busy), 16'h0000);
        $display("test continuous done");
        conclude();
    end
endmodule
`default_nettype wire
